/* File: design/guard_pkg.sv */
/*
 * Constants for the command guard slice: command codes, write-guard levels,
 * feature report layout and timing.
 * Assumes a command decoder upstream that delivers whole decoded transactions.
 */
package guard_pkg;
    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_SETUP = 8'h02;
    localparam logic [7:0] CMD_PHASE = 8'h04;
    localparam logic [7:0] CMD_WRITE_GUARD = 8'h10;
    localparam logic [7:0] CMD_SAVE_NVM = 8'h15;
    localparam logic [7:0] CMD_LOAD_NVM = 8'h16;
    localparam logic [7:0] CMD_FEATURE_REPORT = 8'h19;
    localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;
    // Write-guard levels
    localparam logic [7:0] GUARD_OPEN = 8'h00;
    localparam logic [7:0] GUARD_SETPOINT = 8'h20;
    localparam logic [7:0] GUARD_OPERATION = 8'h40;
    localparam logic [7:0] GUARD_LOCKED = 8'h80;
    // Feature report fields
    localparam logic FEAT_PEC = 1'b1;
    localparam logic [1:0] FEAT_SPEED = 2'b10;
    localparam logic FEAT_ALERT = 1'b1;
    localparam logic FEAT_FORMAT = 1'b0;
    localparam logic FEAT_AVSBUS = 1'b0;
    localparam logic [1:0] FEAT_RSVD = 2'b00;
    localparam logic [7:0] FEATURE_VALUE = {FEAT_PEC, FEAT_SPEED, FEAT_ALERT, FEAT_FORMAT, FEAT_AVSBUS, FEAT_RSVD};
    // Phase value meaning all phases together
    localparam logic [7:0] PHASE_ALL = 8'hff;
    // Memory geometry
    localparam int MEM_AW = 8;
    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int SAVE_SETTLE_MS = 100;
    localparam int SAVE_SETTLE_CYC = CLK_HZ / 1000 * SAVE_SETTLE_MS;
    // Phase reset value
    localparam logic [7:0] PHASE_RESET = 8'hff;
endpackage : guard_pkg

/* File: design/store_mem.sv */
/*
 * Small single-port byte memory used for operating memory and user store.
 * Assumes one clock; read data come out of a register one cycle after the address.
 */
module store_mem #(
    parameter int AW = 8
) (
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    // Write then registered read
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : store_mem

/* File: design/cmd_guard.sv */
/*
 * Command guard: write-guard filter, save/load of operating memory to a user
 * store, feature report byte and invalid-data flagging.
 * Assumes an upstream bus engine that presents each decoded command as a
 * one-cycle strobe with code and data, and honours busy as clock stretching.
 */
// Overview of operation
// RULE1 - One-byte write-guard at 10h, byte write and byte read, filters writes.
// RULE2 - Guard 00h lets every supported command be written.
// RULE3 - Guard 20h allows only guard, operation, on/off setup, save, voltage setpoint.
// RULE4 - Guard 40h allows only guard, operation and save writes.
// RULE5 - Guard 80h allows only guard and save writes.
// RULE6 - Undefined guard values are invalid data: flag status and notify host.
// RULE7 - Reads of every command work at any guard level.
// RULE8 - Save command 15h copies operating memory into user store, skipping unmatched items.
// RULE9 - During a save the device may stretch the clock or ignore commands.
// RULE10 - Host should disable regulation and wait 100 ms after a save.
// RULE11 - Host issues save and load only while phase is FFh.
// RULE12 - Load 16h disables operation, copies store back, then applies strap overrides.
// RULE13 - Feature report at 19h, bit 7 set for packet error checking.
// RULE14 - Feature report bits 6:5 read 10b for 1 MHz bus speed.
// RULE15 - Feature report bit 4 reads 1: alert pin and alert response present.
// RULE16 - Feature report bit 3 reads 0: linear or direct number format.
// RULE17 - Feature bit 2 reads 0, no AVSBus; bits 1:0 read zero.
// RULE18 - Any write to the feature report is invalid data, flagged and notified.
// RULE19 - Phase FFh addresses all phases together as one entity.
// RULE20 - A guarded-off write leaves the value and is flagged like invalid data.
// RULE21 - Write-guard loads from store at power-up and is saved by the save command; reset clears the stored guard copy, so the boot load gives 00h.
module cmd_guard
    import guard_pkg::*;
#(
    parameter int SETTLE_CYC = SAVE_SETTLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_data,
    input wire logic [7:0] phase_sel,
    input wire logic [255:0] cmd_supported,
    input wire logic [255:0] store_backed,
    input wire logic [255:0] strap_override,
    input wire logic [7:0] strap_addr,
    input wire logic [7:0] strap_value,
    input wire logic strap_valid,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic invalid_data,
    output logic alert_req,
    output logic regulation_off,
    output logic [7:0] write_guard_level,
    output logic op_we,
    output logic [7:0] op_addr,
    output logic [7:0] op_wdata
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BOOT = 3'b001,
        ST_SAVE = 3'b010,
        ST_LOAD = 3'b011,
        ST_STRAP = 3'b100,
        ST_SETTLE = 3'b101
    } seq_e;

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;
    seq_e state_reg;
    seq_e state_next;
    logic [8:0] idx_reg;
    logic [8:0] idx_next;
    logic [31:0] settle_reg;
    logic [7:0] guard_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic invalid_reg;
    logic alert_reg;
    logic reg_off_reg;
    logic op_we_reg;
    logic [7:0] op_addr_reg;
    logic [7:0] op_wdata_reg;
    logic pipe_reg;
    logic [7:0] pipe_addr_reg;
    logic rd_pend_reg;
    logic rd_mem_reg;
    logic [7:0] rd_fixed_reg;
    logic busy_reg;

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // Command classification
    wire idle = (state_reg == ST_IDLE);
    wire take = cmd_valid && idle;
    wire is_guard = (cmd_code == CMD_WRITE_GUARD);
    wire is_save = (cmd_code == CMD_SAVE_NVM);
    wire is_load = (cmd_code == CMD_LOAD_NVM);
    wire is_feature = (cmd_code == CMD_FEATURE_REPORT);
    wire is_op = (cmd_code == CMD_OPERATION);
    wire is_onoff = (cmd_code == CMD_ON_OFF_SETUP);
    wire is_vout = (cmd_code == CMD_VOUT_SETPOINT);
    wire all_phases = (phase_sel == PHASE_ALL); // [RULE19]

    // Write permission per guard level
    wire allow_l20 = is_guard || is_op || is_onoff || is_save || is_vout; // [RULE3]
    wire allow_l40 = is_guard || is_op || is_save; // [RULE4]
    wire allow_l80 = is_guard || is_save; // [RULE5]
    wire write_allowed = (guard_reg == GUARD_OPEN) ? 1'b1 : // [RULE2]
                         (guard_reg == GUARD_SETPOINT) ? allow_l20 :
                         (guard_reg == GUARD_OPERATION) ? allow_l40 :
                         (guard_reg == GUARD_LOCKED) ? allow_l80 : 1'b0;
    wire guard_val_ok = (cmd_data == GUARD_OPEN) || (cmd_data == GUARD_SETPOINT) ||
                        (cmd_data == GUARD_OPERATION) || (cmd_data == GUARD_LOCKED);

    // Outcome of a taken write
    wire wr_take = take && cmd_write;
    wire wr_refused = wr_take && !write_allowed; // [RULE20]
    wire wr_feature = wr_take && write_allowed && is_feature; // [RULE18]
    wire wr_bad_guard = wr_take && write_allowed && is_guard && !guard_val_ok; // [RULE6]
    wire wr_unsupported = wr_take && write_allowed && !cmd_supported[cmd_code] && !is_guard && !is_save
                          && !is_load && !is_feature;
    wire flag_invalid = wr_refused || wr_feature || wr_bad_guard || wr_unsupported;
    wire guard_load = wr_take && write_allowed && is_guard && guard_val_ok; // [RULE1]
    wire start_save = wr_take && write_allowed && is_save && all_phases; // [RULE8]
    wire start_load = wr_take && write_allowed && is_load && all_phases; // [RULE12]
    wire plain_write = wr_take && write_allowed && !flag_invalid && !is_guard && !is_save && !is_load;
    wire rd_take = take && !cmd_write; // [RULE7]

    // Memory ports
    logic [7:0] op_rdata;
    logic [7:0] us_rdata;
    wire [7:0] idx8 = idx_reg[7:0];
    wire in_save = (state_reg == ST_SAVE);
    wire in_copy_back = (state_reg == ST_LOAD) || (state_reg == ST_BOOT);
    // Save reads ahead by one slot so the registered byte matches pipe_addr_reg
    wire [7:0] opm_addr = (in_save || in_copy_back) ? idx8 : cmd_code;
    wire [7:0] usm_addr = in_save ? pipe_addr_reg : idx8;
    wire usm_we = in_save && pipe_reg && store_backed[pipe_addr_reg] && (pipe_addr_reg != CMD_WRITE_GUARD);
    wire op_copy = in_copy_back && pipe_reg && store_backed[pipe_addr_reg];
    wire guard_from_store = op_copy && (pipe_addr_reg == CMD_WRITE_GUARD); // [RULE21]
    wire strap_apply = (state_reg == ST_STRAP) && strap_valid && strap_override[strap_addr];
    wire opm_we = plain_write || (op_copy && !guard_from_store) || strap_apply;
    wire [7:0] opm_waddr = plain_write ? cmd_code : (strap_apply ? strap_addr : pipe_addr_reg);
    wire [7:0] opm_wdata = plain_write ? cmd_data : (strap_apply ? strap_value : us_rdata);
    wire [7:0] save_byte = (pipe_addr_reg == CMD_WRITE_GUARD) ? guard_reg : op_rdata;

    // Operating memory holds live command values
    store_mem #(.AW(MEM_AW)) u_operating (
        .ref_clk(ref_clk),
        .we(opm_we),
        .addr(opm_we ? opm_waddr : opm_addr),
        .wdata(opm_wdata),
        .rdata(op_rdata)
    );

    // User store, written only by save; guard byte kept in its own register copy
    // Stored guard copy starts open so the boot load never pulls in an unknown level
    logic [7:0] us_guard_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            us_guard_reg <= GUARD_OPEN;
        end else if (in_save && pipe_reg && pipe_addr_reg == CMD_WRITE_GUARD) begin
            us_guard_reg <= guard_reg; // [RULE21]
        end
    end
    store_mem #(.AW(MEM_AW)) u_user_store (
        .ref_clk(ref_clk),
        .we(usm_we),
        .addr(usm_we ? pipe_addr_reg : usm_addr),
        .wdata(save_byte),
        .rdata(us_rdata)
    );

    // Sequencer next state
    wire idx_last = idx_reg[8];
    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        case (state_reg)
            ST_BOOT, ST_SAVE, ST_LOAD: begin
                idx_next = idx_reg + 9'h001;
                if (idx_last) begin
                    idx_next = 9'h000;
                    state_next = (state_reg == ST_SAVE) ? ST_SETTLE : ST_STRAP; // [RULE12]
                end
            end
            ST_STRAP: begin
                if (!strap_valid) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SETTLE: begin
                if (settle_reg == 32'h0) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (start_save) begin
                    state_next = ST_SAVE;
                end else if (start_load) begin
                    state_next = ST_LOAD;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_BOOT; // [RULE21]
            idx_reg <= 9'h000;
            pipe_reg <= 1'b0;
            pipe_addr_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            pipe_reg <= (in_save || in_copy_back) && !idx_last;
            pipe_addr_reg <= idx8;
        end
    end

    // Settle time after save: further commands are held off
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_reg <= 32'h0;
        end else if (in_save) begin
            settle_reg <= 32'(SETTLE_CYC); // [RULE9]
        end else if (settle_reg != 32'h0) begin
            settle_reg <= settle_reg - 32'h1;
        end
    end

    // Guard level register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_reg <= GUARD_OPEN;
        end else if (guard_load) begin
            guard_reg <= cmd_data; // [RULE1]
        end else if (guard_from_store) begin
            guard_reg <= us_guard_reg; // [RULE21]
        end
    end

    // Read answers: feature report is constant, guard is live, others from memory
    // Memory data lag the code by one cycle, so the answer leaves two cycles after the take
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_reg <= 1'b0;
            rd_mem_reg <= 1'b0;
            rd_fixed_reg <= 8'h00;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_pend_reg <= rd_take;
            rd_valid_reg <= rd_pend_reg;
            if (rd_take) begin
                rd_mem_reg <= !is_feature && !is_guard;
                rd_fixed_reg <= is_feature ? FEATURE_VALUE : guard_reg; // [RULE13] [RULE14] [RULE15] [RULE16] [RULE17]
            end
            if (rd_pend_reg) begin
                rd_data_reg <= rd_mem_reg ? op_rdata : rd_fixed_reg; // [RULE7]
            end
        end
    end

    // Invalid data flag and host notification
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            invalid_reg <= 1'b0;
            alert_reg <= 1'b0;
        end else begin
            invalid_reg <= flag_invalid; // [RULE6] [RULE18] [RULE20]
            alert_reg <= alert_reg || flag_invalid;
        end
    end

    // Regulation held off through the load sequence
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_off_reg <= 1'b0;
        end else if (start_load) begin
            reg_off_reg <= 1'b1; // [RULE12]
        end else if (state_reg == ST_STRAP && !strap_valid) begin
            reg_off_reg <= 1'b0;
        end
    end

    // Stretch flag follows the next state, so it matches the state register in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b1;
        end else begin
            busy_reg <= (state_next != ST_IDLE); // [RULE9]
        end
    end

    // Mirror of operating memory writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_we_reg <= 1'b0;
            op_addr_reg <= 8'h00;
            op_wdata_reg <= 8'h00;
        end else begin
            op_we_reg <= opm_we;
            op_addr_reg <= opm_waddr;
            op_wdata_reg <= opm_wdata;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign busy = busy_reg;
    assign invalid_data = invalid_reg;
    assign alert_req = alert_reg;
    assign regulation_off = reg_off_reg;
    assign write_guard_level = guard_reg;
    assign op_we = op_we_reg;
    assign op_addr = op_addr_reg;
    assign op_wdata = op_wdata_reg;

    // Checks
    a_feature_const: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
        (take && !cmd_write && is_feature) |=> ##1 rd_data == 8'hd0) else $error("feature byte wrong");
    a_guard_refuse: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
        (guard_reg == 8'h80 && wr_take && is_op) |=> invalid_data) else $error("locked write not refused");
    a_guard_open: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
        (guard_reg == 8'h00 && wr_take && cmd_supported[cmd_code] && !is_feature && !is_guard) |=> !invalid_data)
        else $error("open guard refused write");
    a_guard_bad: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
        (wr_take && is_guard && !guard_val_ok) |=> ($stable(guard_reg) && invalid_data))
        else $error("bad guard value accepted");
    a_guard_store: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
        (wr_take && is_guard && guard_val_ok) |=> guard_reg == $past(cmd_data)) else $error("guard not stored");
    a_feature_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE18]
        (wr_take && is_feature) |=> invalid_data) else $error("feature write not flagged");
    a_read_any: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
        rd_take |=> (!invalid_data ##1 rd_valid)) else $error("read not answered");
    a_load_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
        start_load |=> (regulation_off && busy)[*2]) else $error("load did not hold off");
    a_refused_kept: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE20]
        wr_refused |=> !op_we) else $error("refused write stored");
endmodule : cmd_guard

/* File: test/pmbus_host_model.sv */
/*
 * Host model: offers one decoded command at a time to the guard block and
 * collects its answer. Assumes every call of xfer starts just after a rising
 * edge of ref_clk.
 */
module pmbus_host_model (
    input wire logic ref_clk,
    input wire logic busy,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic invalid_data,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_data,
    output logic [7:0] phase_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got;
    logic rd_seen;
    logic inv_seen;

    // Idle lines, all phases selected as one entity
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_data = 8'h00;
        phase_sel = 8'hff;
    end

    // One command: wait out any stretch, offer it for one edge, then watch two cycles
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data, input bit wait_idle);
        int n;
        n = 0;
        while (wait_idle && busy !== 1'b0 && n < 4000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_data = data;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        // Released code and data lines never keep the last value
        cmd_code = ~code;
        cmd_data = ~data;
        inv_seen = 1'b0;
        rd_seen = 1'b0;
        repeat (2) begin
            if (invalid_data === 1'b1) inv_seen = 1'b1;
            if (rd_valid === 1'b1) begin
                rd_seen = 1'b1;
                got = rd_data;
            end
            @(posedge ref_clk);
            #1;
        end
    endtask : xfer
endmodule : pmbus_host_model

/* File: test/test_cmd_guard.sv */
/*
 * Self-checking bench for the command guard: guard levels, save and load,
 * feature report and invalid-data flagging.
 * Assumes the host model drives the command port; the bench drives strap inputs.
 */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_cmd_guard;
    timeunit 1ns;
    timeprecision 100ps;
    import guard_pkg::*;
    logic ref_clk, rstn, cmd_valid, cmd_write, strap_valid, rd_valid, busy;
    logic invalid_data, alert_req, regulation_off, op_we;
    logic [7:0] cmd_code, cmd_data, phase_sel, strap_addr, strap_value, rd_data;
    logic [7:0] write_guard_level, op_addr, op_wdata;
    logic [255:0] cmd_supported, store_backed, strap_override;
    int error_cnt = 0;
    int checked = 0;

    cmd_guard #(.SETTLE_CYC(20)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data), .phase_sel(phase_sel),
        .cmd_supported(cmd_supported), .store_backed(store_backed), .strap_override(strap_override),
        .strap_addr(strap_addr), .strap_value(strap_value), .strap_valid(strap_valid),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .invalid_data(invalid_data),
        .alert_req(alert_req), .regulation_off(regulation_off), .write_guard_level(write_guard_level),
        .op_we(op_we), .op_addr(op_addr), .op_wdata(op_wdata));

    pmbus_host_model i_host (.ref_clk(ref_clk), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid),
        .invalid_data(invalid_data), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .phase_sel(phase_sel));

    // Clock at 50 ns period
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // Bounded wait for the end of a stretch
    task automatic idle_wait();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(busy, 1'b0);
    endtask : idle_wait

    // Feature byte fields, and a write to it is refused
    task automatic t_feature();
        i_host.xfer(1'b0, CMD_FEATURE_REPORT, 8'h00, 1'b1);
        `CHK(i_host.rd_seen, 1'b1);
        `CHK(i_host.got[7], 1'b1);
        `CHK(i_host.got[6:5], 2'b10);
        `CHK(i_host.got[4], 1'b1);
        `CHK(i_host.got[3], 1'b0);
        `CHK(i_host.got[2:0], 3'b000);
        `CHK(alert_req, 1'b0);
        i_host.xfer(1'b1, CMD_FEATURE_REPORT, 8'h00, 1'b1);
        `CHK(i_host.inv_seen, 1'b1);
        `CHK(alert_req, 1'b1);
    endtask : t_feature

    // Every guard level against a table of target commands, then bad levels
    task automatic t_guard_levels();
        logic [7:0] lv [4] = '{GUARD_OPEN, GUARD_SETPOINT, GUARD_OPERATION, GUARD_LOCKED};
        logic [7:0] cd [4] = '{CMD_OPERATION, CMD_ON_OFF_SETUP, CMD_VOUT_SETPOINT, 8'h30};
        logic [7:0] bad [3] = '{8'h11, 8'h01, 8'hff};
        logic [7:0] shadow [4];
        logic [7:0] d;
        logic ok;
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(1'b1, CMD_WRITE_GUARD, lv[i], 1'b1);
            `CHK(i_host.inv_seen, 1'b0);
            `CHK(write_guard_level, lv[i]);
            i_host.xfer(1'b0, CMD_WRITE_GUARD, 8'h00, 1'b1);
            `CHK(i_host.got, lv[i]);
            for (int j = 0; j < 4; j++) begin
                d = {4'(i + 1), 4'(j + 1)};
                ok = (i == 0) || (i == 1 && j < 3) || (i == 2 && j == 0);
                i_host.xfer(1'b1, cd[j], d, 1'b1);
                `CHK(i_host.inv_seen, !ok);
                if (ok) shadow[j] = d;
                i_host.xfer(1'b0, cd[j], 8'h00, 1'b1);
                `CHK(i_host.rd_seen, 1'b1);
                `CHK(i_host.got, shadow[j]);
            end
        end
        for (int k = 0; k < 3; k++) begin
            i_host.xfer(1'b1, CMD_WRITE_GUARD, bad[k], 1'b1);
            `CHK(i_host.inv_seen, 1'b1);
            `CHK(write_guard_level, GUARD_LOCKED);
        end
        i_host.xfer(1'b1, CMD_WRITE_GUARD, GUARD_OPEN, 1'b1);
        `CHK(write_guard_level, GUARD_OPEN);
    endtask : t_guard_levels

    // Save under the locked level, change values, load with a strap override
    task automatic t_save_load();
        int n;
        i_host.xfer(1'b1, 8'h30, 8'ha5, 1'b1);
        i_host.xfer(1'b1, CMD_VOUT_SETPOINT, 8'h33, 1'b1);
        i_host.xfer(1'b1, CMD_WRITE_GUARD, GUARD_LOCKED, 1'b1);
        i_host.phase_sel = 8'h00;
        i_host.xfer(1'b1, CMD_SAVE_NVM, 8'h00, 1'b1);
        `CHK(busy, 1'b0);
        i_host.phase_sel = PHASE_ALL;
        i_host.xfer(1'b1, CMD_SAVE_NVM, 8'h00, 1'b1);
        `CHK(i_host.inv_seen, 1'b0);
        `CHK(busy, 1'b1);
        i_host.xfer(1'b1, CMD_WRITE_GUARD, GUARD_OPEN, 1'b0);
        `CHK(write_guard_level, GUARD_LOCKED);
        idle_wait();
        i_host.xfer(1'b1, CMD_WRITE_GUARD, GUARD_OPEN, 1'b1);
        i_host.xfer(1'b1, 8'h30, 8'h11, 1'b1);
        i_host.xfer(1'b1, CMD_VOUT_SETPOINT, 8'h44, 1'b1);
        strap_addr = CMD_VOUT_SETPOINT;
        strap_value = 8'h5a;
        i_host.xfer(1'b1, CMD_LOAD_NVM, 8'h00, 1'b1);
        `CHK(regulation_off, 1'b1);
        strap_valid = 1'b1;
        n = 0;
        while (!(op_we === 1'b1 && op_addr === CMD_VOUT_SETPOINT && op_wdata === 8'h5a) && n < 1000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n < 1000, 1'b1);
        strap_valid = 1'b0;
        idle_wait();
        `CHK(regulation_off, 1'b0);
        `CHK(write_guard_level, GUARD_LOCKED);
        i_host.xfer(1'b0, 8'h30, 8'h00, 1'b1);
        `CHK(i_host.got, 8'ha5);
        i_host.xfer(1'b0, CMD_VOUT_SETPOINT, 8'h00, 1'b1);
        `CHK(i_host.got, 8'h5a);
    endtask : t_save_load

    // Static maps, reset, boot, then the scenarios
    initial begin
        rstn = 1'b0;
        strap_valid = 1'b0;
        strap_addr = 8'h00;
        strap_value = 8'h00;
        cmd_supported = '0;
        store_backed = '0;
        strap_override = '0;
        foreach (cmd_supported[b]) begin
            if (b inside {8'h01, 8'h02, 8'h10, 8'h15, 8'h16, 8'h19, 8'h21, 8'h30}) cmd_supported[b] = 1'b1;
        end
        store_backed[8'h10] = 1'b1;
        store_backed[8'h21] = 1'b1;
        store_backed[8'h30] = 1'b1;
        strap_override[8'h21] = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        idle_wait();
        `CHK(write_guard_level, GUARD_OPEN);
        t_feature();
        t_guard_levels();
        t_save_load();
        close_out();
    end

    // Watchdog against a hang
    initial begin
        #(50 * 20000);
        error_cnt++;
        close_out();
    end
endmodule : test_cmd_guard
